//--- hdl/sxf_pkg.sv
// shared constants, carriers and states of the serial byte port
// assumes one bus clock core_clk and plain-port software control
// Contract
// R01 - master rate-select bits set divider; divided clock paces the master shifter
// R02 - each byte exchanges full duplex: out on MOSI, in on MISO, same clocks
// R03 - master transfer end sets receive-full and moves byte to receive register
// R04 - receive-full clears by status read while set, then data read
// R05 - any data register write clears transmit-empty
// R06 - master-select clear: slave, serial clock pin is an input
// R07 - remote master holds slave select low for a whole transfer
// R08 - slave shifts on external clock; full byte moves out, sets receive-full
// R09 - slave software reads received byte before the next completes
// R10 - master clock at most half bus clock; slave accepts up to bus clock (code samples slave clock on core_clk: half bus clock at most)
// R11 - rate select only affects master clock; slave clock is free
// R12 - slave phase 0: select falling edge starts, MSB driven at once
// R13 - no shift register reload during a transfer; later byte waits
// R14 - slave software writes its byte before select falls in phase 0
// R15 - master starts a queued byte right after previous transfer ends
// R16 - software writes data register only while transmit-empty is high
// R17 - with no new byte, next transfer sends the shift register contents
// R18 - disable keeps flags; master mode fault with detect enabled disables
// R19 - master-select set: drive clock pin, start transfer on data write
// R20 - byte completing while receive-full set sets overrun, keeps old byte
package sxf_pkg;

   localparam int          SXF_DATA_W     = 8;
   localparam int          SXF_FIFO_DEPTH = 8;
   localparam logic [7:0]  SXF_RESET_BYTE = 8'h00;
   localparam logic [3:0]  SXF_EDGE_LAST  = 4'hF;
   localparam logic [3:0]  SXF_EDGE_PH0   = 4'hE;
   localparam logic [3:0]  SXF_EDGE_FIRST = 4'h1;
   localparam logic [3:0]  SXF_EDGE_ZERO  = 4'h0;
   // half serial period minus one, in bus clocks, per rate select
   localparam logic [5:0]  SXF_HALF_R0    = 6'h00;
   localparam logic [5:0]  SXF_HALF_R1    = 6'h03;
   localparam logic [5:0]  SXF_HALF_R2    = 6'h0F;
   localparam logic [5:0]  SXF_HALF_R3    = 6'h3F;

   typedef struct packed {
      logic port_enable_bit;
      logic master_select_bit;
      logic clk_pol;
      logic clk_phase;
      logic fault_detect_enable;
      logic rate_select_high;
      logic rate_select_low;
   } sxf_cfg_t;

   typedef struct packed {
      logic receive_full_flag;
      logic transmit_empty_flag;
      logic overrun_flag;
      logic fault_flag;
      logic busy;
   } sxf_flags_t;

   typedef enum logic [1:0] {
      SXF_IDLE = 2'b01,
      SXF_XFER = 2'b10
   } sxf_state_t;

endpackage

//--- hdl/sxf_fifo.sv
// first-in first-out queue with valid/ready on both sides
// assumes DEPTH is a power of two
`timescale 1ns/1ps
module sxf_fifo
#(
   parameter int W     = 8,
   parameter int DEPTH = 8
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output      logic         in_ready,
   output      logic         out_valid,
   output      logic [W-1:0] out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_q;
   logic [AW:0]  rd_q;
   wire          wrap_diff = (wr_q[AW] != rd_q[AW]);
   wire          idx_same  = (wr_q[AW-1:0] == rd_q[AW-1:0]);
   wire          full  = wrap_diff && idx_same;
   wire          empty = (wr_q == rd_q);
   wire          push  = in_valid & ~full;
   wire          pop   = out_ready & ~empty;

   assign in_ready  = ~full;
   assign out_valid = ~empty;
   assign out_data  = mem[rd_q[AW-1:0]];

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_q[AW-1:0]] <= in_data;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
      end
   end
endmodule

//--- hdl/sxf_clkdiv.sv
// half-period tick generator for the master serial clock
// assumes run is held for the whole transfer; counter restarts when low
`timescale 1ns/1ps
module sxf_clkdiv
   import sxf_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic run,
   input  wire logic rate_select_high,
   input  wire logic rate_select_low,
   output      logic tick
);
   function automatic logic [5:0] half_limit(input logic hi, input logic lo);
      case ({hi, lo})
         2'b00:   half_limit = SXF_HALF_R0;
         2'b01:   half_limit = SXF_HALF_R1;
         2'b10:   half_limit = SXF_HALF_R2;
         default: half_limit = SXF_HALF_R3;
      endcase
   endfunction

   logic [5:0] cnt_q;
   wire  [5:0] limit = half_limit(rate_select_high, rate_select_low); // see R01
   wire        wrap  = (cnt_q == limit);

   // fastest setting toggles every bus clock: half the bus rate
   assign tick = run & wrap; // see R10

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= 6'h00;
      else if (!run || wrap)
         cnt_q <= 6'h00;
      else
         cnt_q <= cnt_q + 6'h01;
   end
endmodule

//--- hdl/sxf_port.sv
// serial byte port, master or slave, with queued transmit bytes
// assumes pins are synchronous to core_clk; pads resolve the enables
`timescale 1ns/1ps
module sxf_port
(
   input  wire logic                   core_clk,
   input  wire logic                   rst_b,
   input  wire sxf_pkg::sxf_cfg_t      cfg,
   input  wire logic                   tx_valid,
   input  wire logic [7:0]             tx_data,
   output      logic                   tx_ready,
   input  wire logic                   status_read,
   input  wire logic                   data_read,
   input  wire logic                   fault_clear,
   output      logic [7:0]             rx_data,
   output      sxf_pkg::sxf_flags_t    flags,
   input  wire logic                   serial_clock_pin_in,
   output      logic                   serial_clock_pin_out,
   output      logic                   serial_clock_pin_oe,
   input  wire logic                   mosi_in,
   output      logic                   mosi_out,
   output      logic                   mosi_oe,
   input  wire logic                   miso_in,
   output      logic                   miso_out,
   output      logic                   miso_oe,
   input  wire logic                   ss_b_in
);
   import sxf_pkg::*;

   // reset release through two flops
   logic       rst_s1_q;
   logic       rst_n_q;

   logic       sclk_prev_q;
   logic       ss_prev_q;
   sxf_state_t state_q;
   logic [3:0] edge_cnt_q;
   logic [7:0] sr_q;
   logic       out_q;
   logic       sclk_q;
   logic [7:0] txbuf_q;
   logic       tx_full_q;
   logic [7:0] rx_q;
   logic       rf_q;
   logic       ovr_q;
   logic       fault_q;
   logic       armed_q;

   logic       fifo_valid;
   logic [7:0] fifo_data;
   logic       tick;

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // mode and enable decode
   wire is_master  = cfg.master_select_bit;
   wire active     = cfg.port_enable_bit & ~fault_q; // see R18
   wire idle       = (state_q == SXF_IDLE);
   wire xfer       = (state_q == SXF_XFER);
   wire mode_fault = active & is_master & cfg.fault_detect_enable & ~ss_b_in;

   // slave clock seen as a sampled level; no rate constraint applied
   wire ss_fall    = ss_prev_q & ~ss_b_in;
   wire sedge      = (serial_clock_pin_in ^ sclk_prev_q) & ~ss_b_in; // see R11
   wire slead      = sedge & (sclk_prev_q == cfg.clk_pol);
   wire mlead      = tick & (sclk_q == cfg.clk_pol);

   wire edge_now   = is_master ? tick : sedge; // see R06
   wire leading    = is_master ? mlead : slead;
   wire sample_e   = edge_now & (leading ^ cfg.clk_phase);
   wire drive_e    = edge_now & ~(leading ^ cfg.clk_phase);
   wire din        = is_master ? miso_in : mosi_in; // see R02
   wire [7:0] sr_shift = {sr_q[6:0], din};

   // with nothing queued a slave sends the shift contents, the last byte received
   wire [7:0] load_val = tx_full_q ? txbuf_q : sr_q; // see R17

   // master waits for a queued byte, starts as soon as one is there
   wire start_m  = active & is_master & idle & tx_full_q & ~mode_fault; // see R15, R19
   wire start_s0 = active & ~is_master & idle & ss_fall & ~cfg.clk_phase; // see R12
   wire start_s1 = active & ~is_master & idle & ~ss_b_in & cfg.clk_phase & slead;
   wire start    = start_m | start_s0 | start_s1;

   wire done_m   = xfer & is_master & tick & (edge_cnt_q == SXF_EDGE_LAST); // see R03
   wire [3:0] s_last = cfg.clk_phase ? SXF_EDGE_LAST : SXF_EDGE_PH0;
   wire done_s   = xfer & ~is_master & sample_e & (edge_cnt_q == s_last); // see R08
   wire abort    = xfer & (~active | mode_fault | (~is_master & ss_b_in));
   wire done     = (done_m | done_s) & ~abort;
   wire [7:0] rx_byte = sample_e ? sr_shift : sr_q;

   // buffer refills from the queue only when empty
   wire load_buf  = fifo_valid & ~tx_full_q; // see R16
   wire rd_clear  = data_read & armed_q;
   wire ovr_set   = done & rf_q & ~rd_clear; // see R20

   sxf_fifo
   #(
      .W     (SXF_DATA_W),
      .DEPTH (SXF_FIFO_DEPTH)
   )
   u_fifo
   (
      .clk       (core_clk),
      .rst_n     (rst_n_q),
      .in_valid  (tx_valid),
      .in_data   (tx_data),
      .in_ready  (tx_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (load_buf)
   );

   sxf_clkdiv u_div
   (
      .core_clk         (core_clk),
      .rst_n            (rst_n_q),
      .run              (xfer & is_master),
      .rate_select_high (cfg.rate_select_high),
      .rate_select_low  (cfg.rate_select_low),
      .tick             (tick)
   );

   // pin sampling history
   always_ff @(posedge core_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         sclk_prev_q <= 1'b0;
         ss_prev_q   <= 1'b1;
      end
      else
      begin
         sclk_prev_q <= serial_clock_pin_in;
         ss_prev_q   <= ss_b_in;
      end
   end

   // transfer sequencer
   always_ff @(posedge core_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         state_q <= SXF_IDLE;
      else
      begin
         case (state_q)
            SXF_IDLE:
               if (start)
                  state_q <= SXF_XFER;
            SXF_XFER:
               if (done || abort)
                  state_q <= SXF_IDLE;
            default:
               state_q <= SXF_IDLE;
         endcase
      end
   end

   // shifter, edge counter and data pin
   always_ff @(posedge core_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         sr_q       <= SXF_RESET_BYTE;
         out_q      <= 1'b0;
         edge_cnt_q <= SXF_EDGE_ZERO;
      end
      else if (start)
      begin
         sr_q       <= load_val; // see R13
         out_q      <= load_val[7];
         edge_cnt_q <= start_s1 ? SXF_EDGE_FIRST : SXF_EDGE_ZERO;
      end
      else if (xfer && edge_now)
      begin
         edge_cnt_q <= edge_cnt_q + 4'h1;
         if (sample_e)
            sr_q <= sr_shift; // see R02
         if (drive_e)
            out_q <= sr_q[7];
      end
   end

   // master serial clock idles at the selected polarity
   always_ff @(posedge core_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         sclk_q <= 1'b0;
      else if (!xfer || abort)
         sclk_q <= cfg.clk_pol;
      else if (tick)
         sclk_q <= ~sclk_q; // see R01
   end

   // transmit holding register
   always_ff @(posedge core_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         txbuf_q   <= SXF_RESET_BYTE;
         tx_full_q <= 1'b0;
      end
      else if (load_buf)
      begin
         txbuf_q   <= fifo_data;
         tx_full_q <= 1'b1; // see R05
      end
      else if (start)
         tx_full_q <= 1'b0;
   end

   // receive register and flags; a completing byte beats a clear
   always_ff @(posedge core_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         rx_q    <= SXF_RESET_BYTE;
         rf_q    <= 1'b0;
         ovr_q   <= 1'b0;
         armed_q <= 1'b0;
      end
      else
      begin
         if (done && !ovr_set)
            rx_q <= rx_byte; // see R03, R08
         rf_q  <= done | (rf_q & ~rd_clear); // see R04
         ovr_q <= ovr_set | (ovr_q & ~rd_clear);
         if (status_read && (rf_q || ovr_q))
            armed_q <= 1'b1; // see R04
         else if (data_read)
            armed_q <= 1'b0;
      end
   end

   // mode fault locks the port off until acknowledged
   always_ff @(posedge core_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         fault_q <= 1'b0;
      else
         fault_q <= mode_fault | (fault_q & ~fault_clear); // see R18
   end

   assign rx_data                   = rx_q;
   assign flags.receive_full_flag   = rf_q;
   assign flags.transmit_empty_flag = ~tx_full_q;
   assign flags.overrun_flag        = ovr_q;
   assign flags.fault_flag          = fault_q;
   assign flags.busy                = xfer;

   assign serial_clock_pin_out = sclk_q;
   assign serial_clock_pin_oe  = active & is_master; // see R19
   assign mosi_out             = out_q;
   assign mosi_oe              = active & is_master;
   assign miso_out             = out_q;
   assign miso_oe              = active & ~is_master & ~ss_b_in; // see R12
endmodule

//--- verification/sxf_port_assertions.sv
// checker for the serial byte port top-level pins
// assumes bind onto sxf_port; all sampling on core_clk
`timescale 1ns/1ps
module sxf_port_assertions
(
   input wire logic                core_clk,
   input wire logic                rst_b,
   input wire sxf_pkg::sxf_cfg_t   cfg,
   input wire logic                tx_valid,
   input wire logic                tx_ready,
   input wire logic                data_read,
   input wire logic [7:0]          rx_data,
   input wire sxf_pkg::sxf_flags_t flags,
   input wire logic                serial_clock_pin_out,
   input wire logic                serial_clock_pin_oe,
   input wire logic                miso_oe,
   input wire logic                ss_b_in
);
   import sxf_pkg::*;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   a_slave_no_clk : assert property (
      !cfg.master_select_bit |-> !serial_clock_pin_oe)
      else $error("clock pin driven in slave mode");
   a_master_clk_oe : assert property (
      flags.busy && cfg.master_select_bit |-> serial_clock_pin_oe)
      else $error("master transfer without clock drive");
   a_done_sets_full : assert property (
      $fell(flags.busy) && cfg.master_select_bit && cfg.port_enable_bit
      && !flags.fault_flag |-> ##[0:2] flags.receive_full_flag)
      else $error("transfer end without receive full");
   a_push_clears_empty : assert property (
      tx_valid && tx_ready && flags.transmit_empty_flag && !flags.busy
      |-> ##2 !flags.transmit_empty_flag)
      else $error("write left transmit empty set");
   a_full_holds : assert property (
      flags.receive_full_flag && !data_read |=> flags.receive_full_flag)
      else $error("receive full cleared without data read");
   a_full_clear_cause : assert property (
      $fell(flags.receive_full_flag) |-> $past(data_read))
      else $error("receive full fell with no data read");
   a_overrun_keeps : assert property (
      $rose(flags.overrun_flag) |-> $stable(rx_data) ##1 $stable(rx_data))
      else $error("overrun replaced the received byte");
   a_rate_one_hold : assert property (
      flags.busy && cfg.master_select_bit && !cfg.rate_select_high
      && cfg.rate_select_low && $changed(serial_clock_pin_out)
      |=> $stable(serial_clock_pin_out) [*3])
      else $error("serial clock half period too short");
   a_slave_start : assert property (
      $fell(ss_b_in) && !cfg.master_select_bit && !cfg.clk_phase
      && cfg.port_enable_bit && !flags.busy |-> ##[1:3] miso_oe && flags.busy)
      else $error("select fall did not start slave transfer");
   a_disable_keeps : assert property (
      !cfg.port_enable_bit && flags.overrun_flag && !data_read
      |=> flags.overrun_flag)
      else $error("disable cleared the overrun flag");
endmodule

bind sxf_port sxf_port_assertions chk_u (.core_clk, .rst_b, .cfg,
   .tx_valid, .tx_ready, .data_read, .rx_data, .flags,
   .serial_clock_pin_out, .serial_clock_pin_oe, .miso_oe, .ss_b_in);

//--- verification/sxf_remote_slave.sv
// remote serial slave, clock mode 0, far side of the master port
// assumes the bench drives select low for a whole transfer
`timescale 1ns/1ps
module sxf_remote_slave
(
   input  wire logic       ser_clk,
   input  wire logic       mosi,
   input  wire logic       sel_b,
   input  wire logic [7:0] load_byte,
   output      logic       miso,
   output      logic [7:0] rx_byte
);
   logic [7:0] shift_q = 8'h00;
   logic       bit_q   = 1'b0;
   always @(negedge sel_b)
      shift_q = load_byte;
   always @(posedge ser_clk)
      if (!sel_b)
         bit_q = mosi;
   always @(negedge ser_clk)
      if (!sel_b)
         shift_q = {shift_q[6:0], bit_q};
   // released line shows the inverse level
   assign miso    = sel_b ? ~shift_q[7] : shift_q[7];
   assign rx_byte = shift_q;
endmodule

//--- verification/testbench.sv
// self-checking bench for the serial byte port, master and slave
// assumes clock mode 0 and a remote slave model on the far side
`timescale 1ns/1ps
module testbench;
   import sxf_pkg::*;
   logic       core_clk = 1'b0;
   logic       rst_b    = 1'b0;
   logic       tx_valid = 1'b0;
   logic       s_rd     = 1'b0;
   logic       d_rd     = 1'b0;
   logic       tb_sclk  = 1'b0;
   logic       tb_mosi  = 1'b0;
   logic       ss_b     = 1'b1;
   logic       sel_b    = 1'b1;
   logic [7:0] tx_data  = 8'h00;
   logic [7:0] pload    = 8'h00;
   sxf_cfg_t   cfg      = '0;
   logic [7:0] rx_data, p_rx;
   sxf_flags_t flags;
   logic       tx_ready, sco, scoe, mo, moe, so, soe, p_miso;
   logic [5:0] half [4] = '{SXF_HALF_R0, SXF_HALF_R1, SXF_HALF_R2,
                            SXF_HALF_R3};
   int         errors = 0;
   int         tests_run = 0;
   int         cycles = 0;
   wire        sclk_w = scoe ? sco : tb_sclk;
   wire        mosi_w = moe ? mo : tb_mosi;
   wire        miso_w = soe ? so : p_miso;

   sxf_port dut_u (.core_clk, .rst_b, .cfg, .tx_valid, .tx_data, .tx_ready,
      .status_read(s_rd), .data_read(d_rd), .fault_clear(1'b0), .rx_data,
      .flags, .serial_clock_pin_in(sclk_w), .serial_clock_pin_out(sco),
      .serial_clock_pin_oe(scoe), .mosi_in(mosi_w), .mosi_out(mo),
      .mosi_oe(moe), .miso_in(miso_w), .miso_out(so), .miso_oe(soe),
      .ss_b_in(ss_b));
   sxf_remote_slave far_u (.ser_clk(sclk_w), .mosi(mosi_w), .sel_b,
      .load_byte(pload), .miso(p_miso), .rx_byte(p_rx));

   always #20 core_clk = ~core_clk;

   task summarize;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         summarize;
      end
   end

   task chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task step(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task push(input logic [7:0] b);
      tx_valid = 1'b1;
      tx_data = b;
      step(1);
      tx_valid = 1'b0;
      step(1);
   endtask

   task wait_busy(input logic v);
      for (int n = 0; n < 3000 && flags.busy !== v; n++)
         step(1);
   endtask

   task clear_rx;
      d_rd = 1'b1;
      step(1);
      d_rd = 1'b0;
      step(1);
      chk(flags.receive_full_flag, 8'h01);
      s_rd = 1'b1;
      step(1);
      s_rd = 1'b0;
      d_rd = 1'b1;
      step(1);
      d_rd = 1'b0;
      step(1);
      chk(flags.receive_full_flag, 8'h00);
      chk(flags.overrun_flag, 8'h00);
   endtask

   task m_xfer(input int r, input logic [7:0] s, input logic [7:0] p);
      int n;
      cfg = sxf_cfg_t'(7'h60 | 7'(r));
      pload = p;
      sel_b = 1'b0;
      push(s);
      for (n = 0; n < 500 && sco === 1'b0; n++)
         step(1);
      for (n = 0; n < 500 && sco === 1'b1; n++)
         step(1);
      chk(8'(n), 8'(half[r]) + 8'h01);
      chk(8'(moe), 8'h01);
      chk(flags.fault_flag, 8'h00);
      wait_busy(1'b0);
      step(2);
      sel_b = 1'b1;
      chk(rx_data, p);
      chk(p_rx, s);
      clear_rx;
   endtask

   task fill_drain;
      int n;
      cfg = sxf_cfg_t'(7'h20);
      for (int k = 0; k < 9; k++)
         push(8'h10 + 8'(k));
      chk(tx_ready, 8'h00);
      chk(flags.transmit_empty_flag, 8'h00);
      pload = 8'h77;
      sel_b = 1'b0;
      step(1);
      cfg.port_enable_bit = 1'b1;
      wait_busy(1'b1);
      for (int k = 0; k < 9; k++)
      begin
         wait_busy(1'b0);
         for (n = 0; n < 5 && flags.busy !== 1'b1; n++)
            step(1);
         if (k < 8)
            chk(8'(n <= 2), 8'h01);
      end
      chk(p_rx, 8'h18);
      chk(rx_data, 8'h77);
      chk(flags.overrun_flag, 8'h01);
      chk(tx_ready, 8'h01);
      cfg.port_enable_bit = 1'b0;
      step(2);
      chk(flags.overrun_flag, 8'h01);
      sel_b = 1'b1;
      clear_rx;
   endtask

   task s_xfer(input logic [7:0] exp, input logic [7:0] m, input logic mid,
               input logic [7:0] nb);
      ss_b = 1'b0;
      step(2);
      for (int i = 7; i >= 0; i--)
      begin
         chk(8'(so), 8'(exp[i]));
         chk(8'(soe), 8'h01);
         chk(8'(moe), 8'h00);
         tb_mosi = m[i];
         if (mid && i == 4)
            push(nb);
         step(1);
         tb_sclk = 1'b1;
         step(2);
         tb_sclk = 1'b0;
         step(2);
      end
      ss_b = 1'b1;
      step(2);
      chk(rx_data, m);
      clear_rx;
   endtask

   initial
   begin
      step(8);
      rst_b = 1'b1;
      step(4);
      for (int r = 0; r < 4; r++)
         m_xfer(r, 8'hA5 ^ 8'(r), 8'h3C + 8'(r));
      fill_drain;
      cfg = sxf_cfg_t'(7'h40);
      push(8'hA6);
      s_xfer(8'hA6, 8'h5A, 1'b1, 8'hC9);
      s_xfer(8'hC9, 8'h3E, 1'b0, 8'h00);
      s_xfer(8'h3E, 8'h81, 1'b0, 8'h00);
      summarize;
   end
endmodule
